// ### hw/amc_mode_regs.sv
// converter mode-control register bank with serial configuration port
//
// What this block does
// - duty stabilizer runs when its disable bit is clear, bypassed when set.
// - three-bit drive code maps to seven currents, 000=3.5mA to 111=1.8mA, 011 unused.
// - pattern force bit set drives the test pattern, clear gives conversion data.
// - pattern bits 15..8 come from the high-byte register.
// - pattern bits 7..0 come from the low-byte register.
// - format/power register at 01h, output drive register at 02h.
// - scramble xors every data bit above the lsb with the lsb.
// - forced pattern bypasses both signed formatting and scrambling.
// - 16-bit word rw,addr7,data8; only first 16 edges count; reads never write.
// - sleep downs everything; nap per channel; wake from nap takes 100 clocks.
`timescale 1ns/1ps
module amc_mode_regs #(
    parameter int DATA_W = 16
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    // serial configuration port, synchronous to clk_sys
    input  wire logic              cs_b,
    input  wire logic              sck,
    input  wire logic              sdi,
    output logic                   sdo_out,
    output logic                   sdo_oe_b,
    // conversion data in, one per channel
    input  wire logic [DATA_W-1:0] conv_a,
    input  wire logic [DATA_W-1:0] conv_b,
    // formatted data out
    output logic [DATA_W-1:0]      data_out_a,
    output logic [DATA_W-1:0]      data_out_b,
    // mode controls
    output logic                   duty_stabilizer_on,
    output logic [5:0]             drive_current_tenth_ma,
    output logic                   internal_termination_enable,
    output logic                   output_drivers_disable,
    output logic [2:0]             lane_count,
    output logic                   sleep_active,
    output logic                   nap_a_active,
    output logic                   nap_b_active,
    output logic                   channel_a_ready,
    output logic                   channel_b_ready
);
    // ----------------------------------------
    // reset synchroniser
    // ----------------------------------------
    logic rst_meta_b;
    logic rst_sync_b;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    function automatic logic [DATA_W-1:0] amc_format(
        input logic [DATA_W-1:0] raw,
        input logic              signed_sel,
        input logic              scramble,
        input logic              force_pat,
        input logic [DATA_W-1:0] pattern
    );
        logic [DATA_W-1:0] v;
        v = raw;
        if (signed_sel) begin
            v[DATA_W-1] = ~v[DATA_W-1];
        end
        if (scramble) begin
            v[DATA_W-1:1] = v[DATA_W-1:1] ^ {(DATA_W-1){v[0]}};
        end
        if (force_pat) begin
            v = pattern;
        end
        return v;
    endfunction

    // ----------------------------------------
    // serial port and registers
    // ----------------------------------------
    amc_pkg::amc_ser_state_t state, next_state;
    logic       sck_prev, next_sck_prev;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [15:0] shift, next_shift;
    logic [7:0] rd_data, next_rd_data;
    logic [7:0] fmt_reg, next_fmt_reg;
    logic [7:0] drv_reg, next_drv_reg;
    logic [7:0] pat_hi, next_pat_hi;
    logic [7:0] pat_lo, next_pat_lo;
    logic       next_sdo_q;
    logic       rise;

    assign rise = sck & ~sck_prev;

    always_comb begin
        next_state   = state;
        next_sck_prev = sck;
        next_bit_cnt = bit_cnt;
        next_shift   = shift;
        next_rd_data = rd_data;
        next_fmt_reg = fmt_reg;
        next_drv_reg = drv_reg;
        next_pat_hi  = pat_hi;
        next_pat_lo  = pat_lo;
        next_sdo_q   = 1'b1;
        if (cs_b) begin
            next_state = amc_pkg::SER_IDLE;
            next_bit_cnt = '0;
        end else begin
            unique case (state)
                amc_pkg::SER_IDLE, amc_pkg::SER_SHIFT: begin
                    next_state = amc_pkg::SER_SHIFT;
                    // rw bit sits bit_cnt-1 places up, it keeps moving as data shifts in
                    if (bit_cnt > amc_pkg::ADDR_DONE && shift[4'(bit_cnt - 5'h01)]) begin
                        // read data shifts out msb first after the address
                        next_sdo_q = rd_data[7];
                    end
                    if (rise) begin
                        next_shift = {shift[14:0], sdi};
                        next_bit_cnt = bit_cnt + 5'h01;
                        if (bit_cnt == amc_pkg::ADDR_DONE) begin
                            unique case ({shift[5:0], sdi})
                                amc_pkg::ADDR_FORMAT_POWER: next_rd_data = fmt_reg;
                                amc_pkg::ADDR_OUTPUT_DRIVE: next_rd_data = drv_reg;
                                amc_pkg::ADDR_PATTERN_HIGH: next_rd_data = pat_hi;
                                amc_pkg::ADDR_PATTERN_LOW:  next_rd_data = pat_lo;
                                default:                    next_rd_data = '0;
                            endcase
                        end else if (bit_cnt > amc_pkg::ADDR_DONE) begin
                            next_rd_data = {rd_data[6:0], 1'b0};
                        end
                        if (bit_cnt == amc_pkg::WORD_LAST) begin
                            next_state = amc_pkg::SER_DONE;
                            if (!shift[14]) begin
                                unique case (shift[13:7])
                                    amc_pkg::ADDR_SOFT_RESET: begin
                                        if (shift[6]) begin
                                            next_fmt_reg = amc_pkg::REG_RESET_VALUE;
                                            next_drv_reg = amc_pkg::REG_RESET_VALUE;
                                            next_pat_hi  = amc_pkg::REG_RESET_VALUE;
                                            next_pat_lo  = amc_pkg::REG_RESET_VALUE;
                                        end
                                    end
                                    amc_pkg::ADDR_FORMAT_POWER: next_fmt_reg = {shift[6:0], sdi};
                                    amc_pkg::ADDR_OUTPUT_DRIVE: next_drv_reg = {shift[6:0], sdi};
                                    amc_pkg::ADDR_PATTERN_HIGH: next_pat_hi  = {shift[6:0], sdi};
                                    amc_pkg::ADDR_PATTERN_LOW:  next_pat_lo  = {shift[6:0], sdi};
                                    default: ;
                                endcase
                            end
                        end
                    end
                end
                amc_pkg::SER_DONE: begin
                    // edges past the sixteenth are ignored until cs rises
                    next_state = amc_pkg::SER_DONE;
                end
                default: next_state = amc_pkg::SER_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state    <= amc_pkg::SER_IDLE;
            sck_prev <= 1'b0;
            bit_cnt  <= '0;
            shift    <= '0;
            rd_data  <= '0;
            fmt_reg  <= amc_pkg::REG_RESET_VALUE;
            drv_reg  <= amc_pkg::REG_RESET_VALUE;
            pat_hi   <= amc_pkg::REG_RESET_VALUE;
            pat_lo   <= amc_pkg::REG_RESET_VALUE;
        end else begin
            state    <= next_state;
            sck_prev <= next_sck_prev;
            bit_cnt  <= next_bit_cnt;
            shift    <= next_shift;
            rd_data  <= next_rd_data;
            fmt_reg  <= next_fmt_reg;
            drv_reg  <= next_drv_reg;
            pat_hi   <= next_pat_hi;
            pat_lo   <= next_pat_lo;
        end
    end

    // ----------------------------------------
    // decoded outputs and nap recovery
    // ----------------------------------------
    logic [7:0] wake_a, next_wake_a;
    logic [7:0] wake_b, next_wake_b;
    logic [DATA_W-1:0] next_out_a, next_out_b;
    logic [5:0] next_cur;
    logic [2:0] next_lanes;
    logic [DATA_W-1:0] pattern;

    assign pattern = {pat_hi, pat_lo};

    always_comb begin
        next_out_a = amc_format(conv_a, fmt_reg[amc_pkg::SIGNED_FORMAT_BIT],
            fmt_reg[amc_pkg::SCRAMBLE_BIT], drv_reg[amc_pkg::PATTERN_FORCE_BIT], pattern);
        next_out_b = amc_format(conv_b, fmt_reg[amc_pkg::SIGNED_FORMAT_BIT],
            fmt_reg[amc_pkg::SCRAMBLE_BIT], drv_reg[amc_pkg::PATTERN_FORCE_BIT], pattern);
        unique case (drv_reg[amc_pkg::DRIVE_CODE_HI:amc_pkg::DRIVE_CODE_LO])
            3'h0:    next_cur = amc_pkg::CUR_000;
            3'h1:    next_cur = amc_pkg::CUR_001;
            3'h2:    next_cur = amc_pkg::CUR_010;
            3'h4:    next_cur = amc_pkg::CUR_100;
            3'h5:    next_cur = amc_pkg::CUR_101;
            3'h6:    next_cur = amc_pkg::CUR_110;
            3'h7:    next_cur = amc_pkg::CUR_111;
            default: next_cur = amc_pkg::CUR_NONE;
        endcase
        unique case (drv_reg[amc_pkg::LANE_SEL_HI:amc_pkg::LANE_SEL_LO])
            amc_pkg::LANES_TWO:  next_lanes = amc_pkg::LANE_N_TWO;
            amc_pkg::LANES_FOUR: next_lanes = amc_pkg::LANE_N_FOUR;
            amc_pkg::LANES_ONE:  next_lanes = amc_pkg::LANE_N_ONE;
            default:             next_lanes = amc_pkg::LANE_N_TWO;     // unused code
        endcase
        // each channel counts its own wake-up; sleep restarts both
        next_wake_a = wake_a;
        next_wake_b = wake_b;
        if (fmt_reg[amc_pkg::SLEEP_BIT] || fmt_reg[amc_pkg::NAP_A_BIT]) begin
            next_wake_a = '0;
        end else if (wake_a != amc_pkg::NAP_WAKE_COUNT) begin
            next_wake_a = wake_a + 8'h01;
        end
        if (fmt_reg[amc_pkg::SLEEP_BIT] || fmt_reg[amc_pkg::NAP_B_BIT]) begin
            next_wake_b = '0;
        end else if (wake_b != amc_pkg::NAP_WAKE_COUNT) begin
            next_wake_b = wake_b + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wake_a                      <= amc_pkg::NAP_WAKE_COUNT;
            wake_b                      <= amc_pkg::NAP_WAKE_COUNT;
            data_out_a                  <= '0;
            data_out_b                  <= '0;
            duty_stabilizer_on          <= 1'b1;
            drive_current_tenth_ma      <= amc_pkg::CUR_000;
            internal_termination_enable <= 1'b0;
            output_drivers_disable      <= 1'b0;
            lane_count                  <= amc_pkg::LANE_N_TWO;
            sleep_active                <= 1'b0;
            nap_a_active                <= 1'b0;
            nap_b_active                <= 1'b0;
            channel_a_ready             <= 1'b1;
            channel_b_ready             <= 1'b1;
            sdo_out                     <= 1'b0;
            sdo_oe_b                    <= 1'b1;
        end else begin
            wake_a                      <= next_wake_a;
            wake_b                      <= next_wake_b;
            data_out_a                  <= next_out_a;
            data_out_b                  <= next_out_b;
            duty_stabilizer_on          <= ~fmt_reg[amc_pkg::DUTY_DISABLE_BIT];
            drive_current_tenth_ma      <= next_cur;
            internal_termination_enable <= drv_reg[amc_pkg::TERMINATION_BIT];
            output_drivers_disable      <= drv_reg[amc_pkg::DRIVERS_OFF_BIT];
            lane_count                  <= next_lanes;
            sleep_active                <= fmt_reg[amc_pkg::SLEEP_BIT];
            nap_a_active                <= fmt_reg[amc_pkg::NAP_A_BIT];
            nap_b_active                <= fmt_reg[amc_pkg::NAP_B_BIT];
            channel_a_ready             <= (next_wake_a == amc_pkg::NAP_WAKE_COUNT);
            channel_b_ready             <= (next_wake_b == amc_pkg::NAP_WAKE_COUNT);
            // open drain: only ever pulls low
            sdo_out                     <= 1'b0;
            sdo_oe_b                    <= next_sdo_q;
        end
    end
endmodule

// ### hw/amc_pkg.sv
// constants for the converter mode-control register bank
package amc_pkg;
    // ----------------------------------------
    // register addresses (seven-bit space)
    // ----------------------------------------
    localparam logic [6:0] ADDR_SOFT_RESET     = 7'h00;
    localparam logic [6:0] ADDR_FORMAT_POWER   = 7'h01;
    localparam logic [6:0] ADDR_OUTPUT_DRIVE   = 7'h02;
    localparam logic [6:0] ADDR_PATTERN_HIGH   = 7'h03;
    localparam logic [6:0] ADDR_PATTERN_LOW    = 7'h04;
    localparam logic [7:0] REG_RESET_VALUE     = 8'h00;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int SOFT_RESET_BIT      = 7;
    localparam int DUTY_DISABLE_BIT    = 7;
    localparam int SCRAMBLE_BIT        = 6;
    localparam int SIGNED_FORMAT_BIT   = 5;
    localparam int SLEEP_BIT           = 4;
    localparam int NAP_B_BIT           = 3;
    localparam int NAP_A_BIT           = 0;
    localparam int DRIVE_CODE_HI       = 7;
    localparam int DRIVE_CODE_LO       = 5;
    localparam int TERMINATION_BIT     = 4;
    localparam int DRIVERS_OFF_BIT     = 3;
    localparam int PATTERN_FORCE_BIT   = 2;
    localparam int LANE_SEL_HI         = 1;
    localparam int LANE_SEL_LO         = 0;
    // ----------------------------------------
    // serial word layout
    // ----------------------------------------
    localparam int          WORD_BITS    = 16;
    localparam logic [4:0]  WORD_LAST    = 5'h0f;
    localparam logic [4:0]  ADDR_DONE    = 5'h07;
    localparam int          RW_POS       = 15;
    // ----------------------------------------
    // nap recovery
    // ----------------------------------------
    localparam int          NAP_WAKE_CYCLES = 100;
    localparam logic [7:0]  NAP_WAKE_COUNT  = 8'(NAP_WAKE_CYCLES);
    // ----------------------------------------
    // lane codes and drive currents (tenths of mA)
    // ----------------------------------------
    localparam logic [1:0]  LANES_TWO  = 2'h0;
    localparam logic [1:0]  LANES_FOUR = 2'h1;
    localparam logic [1:0]  LANES_ONE  = 2'h2;
    localparam logic [2:0]  LANE_N_ONE  = 3'h1;
    localparam logic [2:0]  LANE_N_TWO  = 3'h2;
    localparam logic [2:0]  LANE_N_FOUR = 3'h4;
    localparam logic [5:0]  CUR_000 = 6'h23;
    localparam logic [5:0]  CUR_001 = 6'h28;
    localparam logic [5:0]  CUR_010 = 6'h2d;
    localparam logic [5:0]  CUR_100 = 6'h1e;
    localparam logic [5:0]  CUR_101 = 6'h19;
    localparam logic [5:0]  CUR_110 = 6'h15;
    localparam logic [5:0]  CUR_111 = 6'h12;
    localparam logic [5:0]  CUR_NONE = 6'h00;
    // ----------------------------------------
    // serial state
    // ----------------------------------------
    typedef enum logic [1:0] {
        SER_IDLE  = 2'b00,
        SER_SHIFT = 2'b01,
        SER_DONE  = 2'b10
    } amc_ser_state_t;
endpackage

// ### verification/amc_mode_regs_props.sv
// concurrent checks on the mode-control register bank ports
`timescale 1ns/1ps
module amc_mode_regs_props #(
    parameter int DATA_W = 16
) (
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              rst_b,
    // serial port
    input wire logic              cs_b,
    input wire logic              sdo_out,
    // data path
    input wire logic [DATA_W-1:0] conv_a,
    input wire logic [DATA_W-1:0] conv_b,
    input wire logic [DATA_W-1:0] data_out_a,
    input wire logic [DATA_W-1:0] data_out_b,
    // mode controls
    input wire logic              duty_stabilizer_on,
    input wire logic [5:0]        drive_current_tenth_ma,
    input wire logic [2:0]        lane_count,
    input wire logic              sleep_active,
    input wire logic              nap_a_active,
    input wire logic              channel_a_ready,
    input wire logic              channel_b_ready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sdo_drain_a: assert property (sdo_out == 1'b0) else $error("sdo driven high");
    lane_legal_a: assert property (lane_count inside {3'h1, 3'h2, 3'h4})
        else $error("illegal lane count");
    current_legal_a: assert property (drive_current_tenth_ma inside
        {6'h23, 6'h28, 6'h2d, 6'h00, 6'h1e, 6'h19, 6'h15, 6'h12}) else $error("bad current");
    // mode control outputs may only move as a result of a serial write
    mode_hold_a: assert property (cs_b [*4] |-> $stable(lane_count)
        && $stable(drive_current_tenth_ma)) else $error("mode moved while idle");
    duty_hold_a: assert property (cs_b [*4] |-> $stable(duty_stabilizer_on)
        && $stable(sleep_active)) else $error("control moved while idle");
    chan_match_a: assert property ($past(conv_a) == $past(conv_b)
        |-> data_out_a == data_out_b) else $error("channels formatted differently");
    nap_block_a: assert property (nap_a_active [*2] |-> !channel_a_ready)
        else $error("ready while napping");
    sleep_block_a: assert property (sleep_active [*2]
        |-> !channel_a_ready && !channel_b_ready) else $error("ready while asleep");
    wake_early_a: assert property ($rose(channel_a_ready) |-> !$past(nap_a_active, 95))
        else $error("nap wake too early");
    wake_late_a: assert property ($fell(nap_a_active) && !sleep_active
        |-> ##[95:105] channel_a_ready) else $error("nap wake too late");
endmodule

// ### verification/amc_mode_regs_tb.sv
// self-checking bench for the mode-control register bank
`timescale 1ns/1ps
module amc_mode_regs_tb;
    localparam int DATA_W = 16;
    // ----------------------------------------
    // clock, reset and stimulus
    // ----------------------------------------
    logic              clk_sys = 1'b0;
    logic              rst_b = 1'b0;
    logic              cs_b, sck, sdi, sdo_out, sdo_oe_b;
    logic [DATA_W-1:0] conv_a = '0, conv_b = '0, data_out_a, data_out_b;
    logic              duty_on, term_en, drv_off, sleep_a, nap_a, nap_b, rdy_a, rdy_b;
    logic [5:0]        cur;
    logic [2:0]        lanes;
    logic [7:0]        rd;
    int                fails = 0;
    int                n_compared = 0;
    always #20 clk_sys = ~clk_sys;
    amc_mode_regs #(.DATA_W(DATA_W)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b),
        .sck(sck), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_b(sdo_oe_b), .conv_a(conv_a),
        .conv_b(conv_b), .data_out_a(data_out_a), .data_out_b(data_out_b),
        .duty_stabilizer_on(duty_on), .drive_current_tenth_ma(cur),
        .internal_termination_enable(term_en), .output_drivers_disable(drv_off),
        .lane_count(lanes), .sleep_active(sleep_a), .nap_a_active(nap_a),
        .nap_b_active(nap_b), .channel_a_ready(rdy_a), .channel_b_ready(rdy_b));
    amc_spi_host host (.clk_sys(clk_sys), .cs_b(cs_b), .sck(sck), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe_b(sdo_oe_b));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        host.xfer(1'b0, a, d, 16, unused);
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] got;
        host.xfer(1'b1, a, 8'hff, 16, got);
        check({8'h00, got}, {8'h00, exp}, "readback");
    endtask
    function automatic logic [15:0] fmt(input logic [15:0] c, input logic s, input logic r);
        logic [15:0] v;
        v = s ? {~c[15], c[14:0]} : c;
        return r ? {v[15:1] ^ {15{v[0]}}, v[0]} : v;
    endfunction
    task automatic report_and_stop();
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        check({15'h0, duty_on}, 16'h1, "stabilizer at reset");
        check({10'h0, cur}, 16'h23, "current at reset");
        check({13'h0, lanes}, 16'h2, "lanes at reset");
        wr(7'h00, 8'h80);
        for (int a = 1; a <= 4; a++) rdchk(7'(a), 8'h00);
    endtask
    task automatic t_format();
        conv_a <= 16'h1235;
        conv_b <= 16'h8ac0;
        for (int m = 0; m < 8; m++) begin
            wr(7'h01, {m[2], m[1], m[0], 5'h00});
            check({15'h0, duty_on}, {15'h0, ~m[2]}, "stabilizer");
            check(data_out_a, fmt(16'h1235, m[0], m[1]), "format a");
            check(data_out_b, fmt(16'h8ac0, m[0], m[1]), "format b");
        end
        rdchk(7'h01, 8'he0);
    endtask
    task automatic t_drive();
        logic [5:0] ma[8] = '{6'h23, 6'h28, 6'h2d, 6'h00, 6'h1e, 6'h19, 6'h15, 6'h12};
        logic [2:0] ln[4] = '{3'h2, 3'h4, 3'h1, 3'h2};
        for (int i = 0; i < 8; i++) begin
            wr(7'h02, {i[2:0], i[0], i[1], 1'b0, i[1:0]});
            check({10'h0, cur}, {10'h0, ma[i]}, "drive current");
            check({13'h0, lanes}, {13'h0, ln[i % 4]}, "lane count");
            check({14'h0, term_en, drv_off}, {14'h0, i[0], i[1]}, "termination and disable");
        end
        rdchk(7'h02, 8'hfb);
    endtask
    task automatic t_pattern();
        wr(7'h03, 8'ha5);
        wr(7'h04, 8'h3c);
        wr(7'h01, 8'h60);
        wr(7'h02, 8'h04);
        check(data_out_a, 16'ha53c, "pattern a");
        check(data_out_b, 16'ha53c, "pattern b");
        wr(7'h02, 8'h00);
        check(data_out_a, fmt(16'h1235, 1'b1, 1'b1), "conversion data back");
    endtask
    task automatic t_serial();
        host.xfer(1'b0, 7'h03, 8'h5a, 19, rd);
        rdchk(7'h03, 8'h5a);
        host.xfer(1'b0, 7'h03, 8'h11, 12, rd);
        host.xfer(1'b1, 7'h03, 8'h22, 16, rd);
        check({8'h00, rd}, 16'h005a, "partial word or read altered register");
        rdchk(7'h03, 8'h5a);
        wr(7'h00, 8'h80);
        rdchk(7'h03, 8'h00);
        wr(7'h05, 8'h77);
        rdchk(7'h05, 8'h00);
    endtask
    task automatic t_power();
        int n;
        wr(7'h01, 8'h01);
        check({14'h0, nap_a, rdy_a}, 16'h2, "nap a");
        check({15'h0, rdy_b}, 16'h1, "channel b unaffected");
        fork
            wr(7'h01, 8'h00);
            begin
                @(negedge nap_a);
                n = 0;
                while (rdy_a !== 1'b1 && n < 200) begin
                    @(posedge clk_sys);
                    n++;
                end
            end
        join
        check({15'h0, 1'(n >= 98 && n <= 102)}, 16'h1, "nap wake time");
        wr(7'h01, 8'h10);
        check({13'h0, sleep_a, rdy_a, rdy_b}, 16'h4, "sleep");
        wr(7'h01, 8'h08);
        check({14'h0, nap_b, rdy_b}, 16'h2, "nap b");
    endtask
    // ----------------------------------------
    // sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_format();
        t_drive();
        t_pattern();
        t_serial();
        t_power();
        report_and_stop();
    end
    // about 4400 cycles expected; generous margin
    initial begin
        repeat (40000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end
endmodule
bind amc_mode_regs amc_mode_regs_props #(.DATA_W(DATA_W)) u_props (.clk_sys(clk_sys),
    .rst_b(rst_b), .cs_b(cs_b), .sdo_out(sdo_out), .conv_a(conv_a), .conv_b(conv_b),
    .data_out_a(data_out_a), .data_out_b(data_out_b),
    .duty_stabilizer_on(duty_stabilizer_on), .drive_current_tenth_ma(drive_current_tenth_ma),
    .lane_count(lane_count), .sleep_active(sleep_active), .nap_a_active(nap_a_active),
    .channel_a_ready(channel_a_ready), .channel_b_ready(channel_b_ready));

// ### verification/amc_spi_host.sv
// serial configuration host model driving the register bank port
`timescale 1ns/1ps
module amc_spi_host (
    // clock
    input wire logic clk_sys,
    // serial port
    output logic     cs_b,
    output logic     sck,
    output logic     sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe_b
);
    logic sdo_wire;
    // open drain with pull-up: released reads high
    assign sdo_wire = sdo_oe_b ? 1'b1 : sdo_out;
    initial begin
        cs_b = 1'b1;
        sck = 1'b0;
        sdi = 1'b1;
    end
    task automatic half(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // nbits under 16 leaves a partial word, over 16 adds edges to be ignored
    task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] d,
                        input int nbits, output logic [7:0] rd);
        logic [15:0] word;
        word = {rw, addr, d};
        rd = 8'h00;
        half(1);
        cs_b <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi <= (i < 16) ? word[15 - i] : ~word[0];
            sck <= 1'b0;
            half(3);
            if (i >= 8 && i < 16) rd[15 - i] = sdo_wire;
            sck <= 1'b1;
            half(3);
        end
        sck <= 1'b0;
        half(3);
        cs_b <= 1'b1;
        // released data line must not look like a held bit
        sdi <= ~sdi;
        half(3);
    endtask
endmodule
